// ---- asrc_pkg.sv ----
// Purpose: Constants for the asynchronous SRAM host controller
// Assumes: 25 MHz controller clock
// Notes: Times in ns or us, cycle counts derived from them
package asrc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int MEM_WORDS = 131072;
    // Read timing
    localparam int ADDR_ACCESS_TIME_NS = 10;
    localparam int SELECT_ACCESS_TIME_NS = 10;
    localparam int DRIVE_ENABLE_ACCESS_TIME_NS = 5;
    localparam int READ_CYCLE_NS = 10;
    // Write timing
    localparam int WRITE_CYCLE_NS = 10;
    localparam int ADDR_VALID_BEFORE_WRITE_END_NS = 8;
    localparam int ADDR_HOLD_AFTER_WRITE_NS = 0;
    localparam int DATA_SETUP_NS = 5;
    localparam int DESELECT_SLEEP_TIME_NS = 10;
    // Power up
    localparam int SUPPLY_TO_FIRST_ACCESS_US = 100;
    // Least times rounded up to whole cycles, at least one
    localparam int RD_ACC_NS = (SELECT_ACCESS_TIME_NS > ADDR_ACCESS_TIME_NS) ?
        SELECT_ACCESS_TIME_NS : ADDR_ACCESS_TIME_NS;
    localparam int RD_CYC_RAW = (RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC = (RD_CYC_RAW < 1) ? 1 : RD_CYC_RAW;
    localparam int WR_CYC_RAW =
        (ADDR_VALID_BEFORE_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
    localparam int PWRUP_CYC = (SUPPLY_TO_FIRST_ACCESS_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
endpackage

// ---- asrc_sync.sv ----
// Purpose: Three-flop input synchroniser with agreement filter, per bit
// Assumes: Asynchronous inputs
// Notes: Output changes once the second and third stages agree
`timescale 1ns/1ps
module asrc_sync #(
    parameter int WIDTH = 8
) (
    // Clock and control
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic o_q;
            always_ff @(posedge clk_in)
            begin
                if (srst_in)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    o_q <= 1'b0;
                end
                else if (ce_in)
                begin
                    s1_q <= async_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                    begin
                        o_q <= s3_q;
                    end
                end
            end
            assign sync_out[i] = o_q;
        end
    endgenerate
endmodule

// ---- asrc_ctrl.sv ----
// Purpose: Host controller that sequences reads and writes to an async 128K x 8 SRAM
// Assumes: 25 MHz clock, one outstanding request, pins driven from flip-flops
// Notes: Strobe phases last whole clock periods; data_pins input is synchronised
// Notes on behaviour
// [RL1] Memory holds 131072 bytes addressed by a 17-bit word address.
// [RL2] Chip select and output drive enable are active low; high disables outputs.
// [RL3] Write happens while chip select and write strobe are both low.
// [RL4] Read happens with select and drive enable low, write strobe high.
// [RL5] Memory floats data pins when deselected, disabled or writing.
// [RL6] Deselected memory sleeps by itself; no command is needed.
// [RL7] Memory reaches power-down within 10 ns after chip select rises.
// [RL8] Read data valid within 10 ns of stable address.
// [RL9] Old read data holds at least 3 ns after address change.
// [RL10] Read data valid 10 ns after select falls, 5 ns after enable falls.
// [RL11] Address stable no later than write overlap starts, lead 0 ns.
// [RL12] Write address valid 8 ns before write end, held until it ends.
// [RL13] Wait at least 100 us after power up before first access.
// [RL14] Write interval is overlap of select low and write strobe low.
// [RL15] Simultaneous rise of select and write strobe keeps outputs floating.
// [RL16] Each strobe state lasts whole clock periods, minimums rounded up.
// [RL17] Controller drives data bus only during a write and the one cycle after it ends.
`timescale 1ns/1ps
module asrc_ctrl
    import asrc_pkg::*;
#(
    parameter int PWRUP_CYCLES = PWRUP_CYC
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // User request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_rdata_out,
    // Memory pins
    output logic [ADDR_W-1:0] word_addr_out,
    output logic sel_n_out,
    output logic drv_en_n_out,
    output logic wr_n_out,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe_out
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [5:0] {
        ST_PWRUP = 6'h01,
        ST_IDLE = 6'h02,
        ST_RD = 6'h04,
        ST_RD_END = 6'h08,
        ST_WR = 6'h10,
        ST_WR_END = 6'h20
    } asrc_state_t;

    typedef struct packed {
        asrc_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic rsp;
        logic sel_n;
        logic drv_n;
        logic wr_n;
        logic oe;
    } asrc_regs_t;

    // Three synchroniser stages plus the agreement register before din_sync moves
    localparam int SYNC_CYC = 4;
    localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(RD_CYC + SYNC_CYC);
    localparam logic [CNT_W-1:0] WR_WAIT = CNT_W'(WR_CYC);

    asrc_regs_t r_q;
    asrc_regs_t r_d;
    logic [DATA_W-1:0] din_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Read data come from a pin, so they pass the synchroniser
    asrc_sync #(
        .WIDTH(DATA_W)
    ) asrc_sync_inst (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .async_in(data_pins_in),
        .sync_out(din_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        r_d = r_q;
        r_d.rsp = 1'b0;
        unique case (r_q.st)
            ST_PWRUP:
            begin
                // Hold off every access until the supply settle time passes
                if (r_q.cnt == CNT_W'(PWRUP_CYCLES - 1)) // RL13
                begin
                    r_d.st = ST_IDLE;
                    r_d.cnt = '0;
                end
                else
                begin
                    r_d.cnt = r_q.cnt + 1'b1;
                end
            end
            ST_IDLE:
            begin
                if (req_valid_in)
                begin
                    // Address set with strobes in same edge: 0 ns lead
                    r_d.addr = req_addr_in; // RL1 RL11
                    r_d.wdata = req_wdata_in;
                    r_d.cnt = '0;
                    r_d.sel_n = 1'b0;
                    if (req_write_in)
                    begin
                        r_d.st = ST_WR;
                        r_d.wr_n = 1'b0; // RL3 RL14
                        r_d.drv_n = 1'b1;
                        r_d.oe = 1'b1;
                    end
                    else
                    begin
                        r_d.st = ST_RD;
                        r_d.drv_n = 1'b0; // RL2 RL4
                        r_d.wr_n = 1'b1;
                        r_d.oe = 1'b0; // RL17
                    end
                end
            end
            ST_RD:
            begin
                // Wait out access time plus synchroniser depth
                if (r_q.cnt == RD_WAIT - 1'b1) // RL8 RL10 RL16
                begin
                    r_d.rdata = din_sync;
                    r_d.rsp = 1'b1;
                    r_d.sel_n = 1'b1;
                    r_d.drv_n = 1'b1;
                    r_d.st = ST_RD_END;
                end
                else
                begin
                    r_d.cnt = r_q.cnt + 1'b1;
                end
            end
            ST_RD_END:
            begin
                // One idle cycle lets the memory float before any write drive
                r_d.st = ST_IDLE;
            end
            ST_WR:
            begin
                if (r_q.cnt == WR_WAIT - 1'b1) // RL12 RL16
                begin
                    // Both strobes rise together; address and data still held
                    r_d.sel_n = 1'b1; // RL15
                    r_d.wr_n = 1'b1;
                    r_d.rsp = 1'b1;
                    r_d.st = ST_WR_END;
                end
                else
                begin
                    r_d.cnt = r_q.cnt + 1'b1;
                end
            end
            ST_WR_END:
            begin
                // Data released a cycle after the write ends: hold time met
                r_d.oe = 1'b0; // RL17
                r_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            r_q.st <= ST_PWRUP;
            r_q.cnt <= '0;
            r_q.addr <= ADDR_RST;
            r_q.wdata <= DATA_RST;
            r_q.rdata <= DATA_RST;
            r_q.rsp <= 1'b0;
            r_q.sel_n <= 1'b1; // RL6 RL7
            r_q.drv_n <= 1'b1;
            r_q.wr_n <= 1'b1;
            r_q.oe <= 1'b0;
        end
        else if (ce_in)
        begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign req_ready_out = (r_q.st == ST_IDLE) && ce_in;
    assign rsp_valid_out = r_q.rsp;
    assign rsp_rdata_out = r_q.rdata;
    assign word_addr_out = r_q.addr;
    assign sel_n_out = r_q.sel_n;
    assign drv_en_n_out = r_q.drv_n;
    assign wr_n_out = r_q.wr_n;
    assign data_pins_out = r_q.wdata;
    assign data_pins_oe_out = r_q.oe;

    ////////////////////////////////////////////////////////////////////////////
    sequence wr_start_s;
        !sel_n_out && !wr_n_out && $past(wr_n_out);
    endsequence

    no_contend_a: assert property (@(posedge clk_in) disable iff (srst_in) // RL17
        data_pins_oe_out |-> drv_en_n_out)
        else $error("Data driven while memory output enabled");

    wr_drive_a: assert property (@(posedge clk_in) disable iff (srst_in) // RL3
        (!sel_n_out && !wr_n_out) |-> data_pins_oe_out)
        else $error("Write strobe low without data driven");

    rd_mode_a: assert property (@(posedge clk_in) disable iff (srst_in) // RL4
        !drv_en_n_out |-> (!sel_n_out && wr_n_out))
        else $error("Drive enable low outside a read");

    wr_addr_hold_a: assert property (@(posedge clk_in) disable iff (srst_in) // RL12
        (!sel_n_out && !wr_n_out) |=> $stable(word_addr_out))
        else $error("Address moved during write");

    wr_len_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in) // RL16
        wr_start_s |-> (!wr_n_out)[*1] ##1 wr_n_out)
        else $error("Write interval wrong length");

    joint_rise_a: assert property (@(posedge clk_in) disable iff (srst_in) // RL15
        ($rose(wr_n_out)) |-> $rose(sel_n_out))
        else $error("Strobes did not rise together");

    oe_release_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in) // RL17
        $rose(wr_n_out) |=> !data_pins_oe_out)
        else $error("Data not released after write");

    pwrup_idle_a: assert property (@(posedge clk_in) disable iff (srst_in) // RL13
        (r_q.st == ST_PWRUP) |-> (sel_n_out && !data_pins_oe_out))
        else $error("Access during power up wait");

    rd_len_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in) // RL10
        $fell(drv_en_n_out) |-> (!drv_en_n_out)[*5] ##1 drv_en_n_out)
        else $error("Read interval wrong length");
endmodule

// ---- asrc_sram_model.sv ----
// Purpose: Behavioural model of the 128K x 8 async memory for the host controller bench
// Assumes: Controller pins change only at its clock edges
// Notes: Undriven data wire shows a pattern that flips every clock
`timescale 1ns/1ps
module asrc_sram_model
    import asrc_pkg::*;
(
    // Clock for the idle pattern only
    input wire logic clk_in,
    // Memory pins
    input wire logic [ADDR_W-1:0] word_addr_in,
    input wire logic sel_n_in,
    input wire logic drv_en_n_in,
    input wire logic wr_n_in,
    input wire logic [DATA_W-1:0] host_data_in,
    input wire logic host_oe_in,
    // Resolved data wire
    output logic [DATA_W-1:0] data_pins_out
);
    logic [DATA_W-1:0] mem_q [MEM_WORDS];
    logic [DATA_W-1:0] rd_q = 8'h00;
    logic [DATA_W-1:0] idle_q = 8'hA5;
    logic rd_en;
    assign rd_en = !sel_n_in && !drv_en_n_in && wr_n_in;
    always @(sel_n_in, wr_n_in, word_addr_in, host_data_in)
        if (!sel_n_in && !wr_n_in)
            mem_q[word_addr_in] = host_data_in;
    // Old data scrambled at once, new data only after access time
    always @(word_addr_in, rd_en)
    begin
        rd_q = ~rd_q;
        rd_q <= #(ADDR_ACCESS_TIME_NS) mem_q[word_addr_in];
    end
    always @(posedge clk_in)
        idle_q <= ~idle_q;
    assign data_pins_out = (host_oe_in && rd_en) ? 8'hXX : host_oe_in ? host_data_in
        : rd_en ? rd_q : idle_q;
endmodule

// ---- async_sram_128k_x8_tb.sv ----
// Purpose: Self-checking bench of the async memory host controller
// Assumes: Power-up wait shortened to PU cycles
// Notes: Memory content survives a controller reset
`timescale 1ns/1ps
module async_sram_128k_x8_tb
    import asrc_pkg::*;
();
    localparam int PU = 4;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic ce_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [ADDR_W-1:0] req_addr_in = ADDR_RST;
    logic [DATA_W-1:0] req_wdata_in = DATA_RST;
    logic req_ready_out, rsp_valid_out, sel_n_out, drv_en_n_out, wr_n_out;
    logic data_pins_oe_out;
    logic [DATA_W-1:0] rsp_rdata_out, data_pins_out, pins_w;
    logic [ADDR_W-1:0] word_addr_out;
    int err_count = 0;
    int n_checks = 0;
    asrc_ctrl #(.PWRUP_CYCLES(PU)) asrc_ctrl_inst (.clk_in, .srst_in, .ce_in, .req_valid_in,
        .req_write_in, .req_addr_in, .req_wdata_in, .req_ready_out, .rsp_valid_out,
        .rsp_rdata_out, .word_addr_out, .sel_n_out, .drv_en_n_out, .wr_n_out,
        .data_pins_in(pins_w), .data_pins_out, .data_pins_oe_out);
    asrc_sram_model asrc_sram_model_inst (.clk_in, .word_addr_in(word_addr_out),
        .sel_n_in(sel_n_out), .drv_en_n_in(drv_en_n_out), .wr_n_in(wr_n_out),
        .host_data_in(data_pins_out), .host_oe_in(data_pins_oe_out), .data_pins_out(pins_w));
    ////////////////////////////////////////////////////////////////////////////////
    initial
        forever #20 clk_in = ~clk_in;
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [ADDR_W-1:0] exp, got);
        n_checks++;
        if (exp !== got)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Reset, then a write request held while power-up wait refuses it
    task automatic do_reset();
        srst_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        chk("sel_n", 1, sel_n_out);
        chk("wr_n", 1, wr_n_out);
        chk("oe", 0, data_pins_oe_out);
        srst_in = 1'b0;
        req_valid_in = 1'b1;
        req_write_in = 1'b1;
        req_addr_in = 17'h1FFFF;
        req_wdata_in = 8'hC3;
        repeat (PU - 1)
        begin
            @(posedge clk_in);
            #1;
            chk("ready", 0, req_ready_out);
            chk("sel_n", 1, sel_n_out);
        end
        @(posedge clk_in);
        #1;
        chk("ready after wait", 1, req_ready_out);
    endtask
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int i;
        req_valid_in = 1'b1;
        req_write_in = w;
        req_addr_in = a;
        req_wdata_in = d;
        i = 0;
        do
        begin
            @(negedge clk_in);
            i++;
        end
        while (req_ready_out !== 1'b1 && i < 100);
        @(posedge clk_in);
        #1;
        req_valid_in = 1'b0;
        i = 0;
        while (sel_n_out !== 1'b0 && i < 3)
        begin
            @(posedge clk_in);
            #1;
            i++;
        end
        chk("sel_n", 0, sel_n_out);
    endtask
    task automatic wait_rsp();
        int i;
        i = 0;
        while (rsp_valid_out !== 1'b1 && i < 8)
        begin
            @(posedge clk_in);
            #1;
            i++;
        end
        chk("rsp", 1, rsp_valid_out);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        xfer(1'b1, a, d);
        chk("wr_n", 0, wr_n_out);
        chk("drv_en_n", 1, drv_en_n_out);
        chk("oe", 1, data_pins_oe_out);
        chk("addr", a, word_addr_out);
        chk("wdata", d, data_pins_out);
        wait_rsp();
        chk("end sel_n", 1, sel_n_out);
        chk("end wr_n", 1, wr_n_out);
        chk("hold addr", a, word_addr_out);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        xfer(1'b0, a, 8'h00);
        chk("drv_en_n", 0, drv_en_n_out);
        chk("wr_n", 1, wr_n_out);
        chk("oe", 0, data_pins_oe_out);
        chk("addr", a, word_addr_out);
        wait_rsp();
        chk("rdata", e, rsp_rdata_out);
        chk("end drv_en_n", 1, drv_en_n_out);
    endtask
    task automatic freeze();
        ce_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        chk("ready frozen", 0, req_ready_out);
        chk("rsp frozen", 1, rsp_valid_out);
        chk("sel_n frozen", 1, sel_n_out);
        ce_in = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        wr(17'h1FFFF, 8'hC3);
        wr(17'h00000, 8'h3C);
        wr(17'h0AAAA, 8'h96);
        rd(17'h1FFFF, 8'hC3);
        rd(17'h00000, 8'h3C);
        freeze();
        rd(17'h0AAAA, 8'h96);
        do_reset();
        wr(17'h1FFFF, 8'hC3);
        rd(17'h00000, 8'h3C);
        complete_run();
    end
    initial
    begin
        #(CLK_PERIOD_NS * 2000);
        err_count++;
        complete_run();
    end
endmodule
